// ==== lpd_regs.vh ====
`ifndef LPD_REGS_VH
`define LPD_REGS_VH
// timing figures in ns, faster grade
`define LPD_RAS_MIN_NS        100
`define LPD_RP_NS             50
`define LPD_CP_NS             10
`define LPD_RCD_NS            30
`define LPD_RAH_NS            15
`define LPD_AR_NS             40
`define LPD_CAC_NS            20
`define LPD_COL_ADDR_ACC_NS   55
`define LPD_CAS_W_NS          30
`define LPD_CRW_NS            55
`define LPD_RWD_NS            100
`define LPD_CWD_NS            20
`define LPD_WP_NS             20
`define LPD_CLK_NS            10
// cycles, least times rounded up
`define LPD_CYC(ns)           (((ns) + `LPD_CLK_NS - 1) / `LPD_CLK_NS)
// long intervals in us
`define LPD_PWRUP_US          100
`define LPD_REF_NORM_US       4000
`define LPD_REF_EXT_US        64000
`define LPD_ROWS              256
`define LPD_INIT_CYCLES       8
`define LPD_CYC_PER_US        100
// opcodes
`define LPD_OP_READ           2'h0
`define LPD_OP_WRITE          2'h1
`define LPD_OP_RMW            2'h2
`endif

// ==== lpd_timer.v ====
`timescale 1ns/10ps
`default_nettype none
// countdown: done_out high once load value has elapsed
module lpd_timer #(
   parameter W = 8
) (
   input  wire         ref_clk_in,
   input  wire         rst_in,
   input  wire         load_in,
   input  wire [W-1:0] value_in,
   output wire         done_out
);
   reg [W-1:0] count;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
         count <= {W{1'b0}};
      else if (load_in)
         count <= value_in;
      else if (count != {W{1'b0}})
         count <= count - {{(W-1){1'b0}}, 1'b1};
   end
   assign done_out = (count == {W{1'b0}}) & ~load_in;
endmodule // lpd_timer
`default_nettype wire

// ==== lpd_refresh.v ====
`timescale 1ns/10ps
`default_nettype none
`include "lpd_regs.vh"
// refresh scheduler: requests one row-only refresh per interval
module lpd_refresh #(
   parameter         INT_W     = 16,
   parameter [15:0]  NORM_INT  = 16'h061A,
   parameter [15:0]  EXT_INT   = 16'h61A8
) (
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire       ext_mode_in,
   input  wire       done_in,
   output reg        req_out,
   output reg  [7:0] row_out
);
   reg [INT_W-1:0] tick;
   wire [INT_W-1:0] limit = ext_mode_in ? EXT_INT : NORM_INT;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         tick    <= {INT_W{1'b0}};
         req_out <= 1'b0;
         row_out <= 8'h00;
      end
      else
      begin
         if (tick >= limit)
         begin
            tick    <= {INT_W{1'b0}};
            req_out <= 1'b1;
         end
         else
            tick <= tick + {{(INT_W-1){1'b0}}, 1'b1};
         // set wins over clear; the refreshed row still advances
         if (done_in && !(tick >= limit))
            req_out <= 1'b0;
         if (done_in)
            row_out <= row_out + 8'h01;
      end
   end
endmodule // lpd_refresh
`default_nettype wire

// ==== lpd_ctrl.v ====
`timescale 1ns/10ps
`default_nettype none
`include "lpd_regs.vh"
module lpd_ctrl #(
   parameter PWRUP_CYC = `LPD_PWRUP_US * `LPD_CYC_PER_US,
   parameter IDLE_CYC  = `LPD_REF_EXT_US * `LPD_CYC_PER_US
) (
   input  wire        ref_clk_in,
   input  wire        rst_in,
   input  wire        req_valid_in,
   input  wire [1:0]  req_op_in,
   input  wire [15:0] req_addr_in,
   input  wire        req_wdata_in,
   input  wire        ext_refresh_in,
   output wire        req_ready_out,
   output reg         rd_valid_out,
   output reg         rd_data_out,
   output reg         init_done_out,
   output reg         ext_active_out,
   output reg         ras_n_out,
   output reg         cas_n_out,
   output reg         we_n_out,
   output reg  [7:0]  mux_address_bus_out,
   output reg         din_out,
   input  wire        dout_in
);
   // ======================================================
   // timing constants
   localparam [7:0] T_RCD = `LPD_CYC(`LPD_RCD_NS);
   localparam [7:0] T_RAS = `LPD_CYC(`LPD_RAS_MIN_NS);
   localparam [7:0] T_RP  = `LPD_CYC(`LPD_RP_NS);
   // column address access dominates at the fixed strobe spacing
   localparam [7:0] T_ACC = `LPD_CYC(`LPD_COL_ADDR_ACC_NS);
   localparam [7:0] T_CW  = `LPD_CYC(`LPD_CAS_W_NS);
   localparam [7:0] T_CRW = `LPD_CYC(`LPD_CRW_NS);
   localparam [7:0] T_WP  = `LPD_CYC(`LPD_WP_NS);
   localparam [15:0] NORM_INT = `LPD_REF_NORM_US * `LPD_CYC_PER_US / `LPD_ROWS;
   localparam [15:0] EXT_INT  = `LPD_REF_EXT_US * `LPD_CYC_PER_US / `LPD_ROWS;
   localparam [3:0] ROWS_LAST = 4'h0;
   localparam [3:0] INIT_CNT  = `LPD_INIT_CYCLES;
   localparam [8:0] ROWS_ALL  = `LPD_ROWS;
   // ======================================================
   // states
   localparam [3:0] S_PWR   = 4'h0;
   localparam [3:0] S_IDLE  = 4'h1;
   localparam [3:0] S_ROW   = 4'h2;
   localparam [3:0] S_COL   = 4'h3;
   localparam [3:0] S_SAMP  = 4'h4;
   localparam [3:0] S_WLATE = 4'h5;
   localparam [3:0] S_CHOLD = 4'h6;
   localparam [3:0] S_RHOLD = 4'h7;
   localparam [3:0] S_PRE   = 4'h8;
   localparam [3:0] S_REF   = 4'h9;

   reg  [3:0]  state;
   reg  [1:0]  op;
   reg  [7:0]  col;
   reg         wbit;
   reg         is_ref;
   reg  [3:0]  init_cnt;
   reg  [8:0]  burst_cnt;
   reg         ext_want;
   reg  [31:0] long_cnt;
   reg         dout_s1;
   reg         dout_s2;
   reg         t_load;
   reg  [7:0]  t_val;
   reg         ras_load;
   wire        t_done;
   wire        ras_done;
   wire        ref_req;
   wire [7:0]  ref_row;
   reg         ref_done;

   // ready only where the idle branch really takes the request
   assign req_ready_out = (state == S_IDLE) && init_done_out && !ref_req
                          && (burst_cnt == 9'h000) && (init_cnt == ROWS_LAST)
                          && !ext_active_out && !ext_want && !ext_refresh_in
                          && (long_cnt < IDLE_CYC);

   lpd_timer #(.W(8)) u_phase (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .load_in    (t_load),
      .value_in   (t_val),
      .done_out   (t_done)
   );

   lpd_timer #(.W(8)) u_ras (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .load_in    (ras_load),
      .value_in   (T_RAS),
      .done_out   (ras_done)
   );

   lpd_refresh #(.INT_W(16), .NORM_INT(NORM_INT), .EXT_INT(EXT_INT)) u_ref (
      .ref_clk_in  (ref_clk_in),
      .rst_in      (rst_in),
      .ext_mode_in (ext_active_out),
      .done_in     (ref_done),
      .req_out     (ref_req),
      .row_out     (ref_row)
   );

   // ======================================================
   // data pin sync; device output is asynchronous
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         dout_s1 <= 1'b0;
         dout_s2 <= 1'b0;
      end
      else
      begin
         dout_s1 <= dout_in;
         dout_s2 <= dout_s1;
      end
   end

   // ======================================================
   // main sequencer
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         state               <= S_PWR;
         op                  <= `LPD_OP_READ;
         col                 <= 8'h00;
         wbit                <= 1'b0;
         is_ref              <= 1'b0;
         init_cnt            <= 4'h0;
         burst_cnt           <= 9'h000;
         ext_want            <= 1'b0;
         ext_active_out      <= 1'b0;
         long_cnt            <= 32'h0;
         init_done_out       <= 1'b0;
         rd_valid_out        <= 1'b0;
         rd_data_out         <= 1'b0;
         ras_n_out           <= 1'b1;
         cas_n_out           <= 1'b1;
         we_n_out            <= 1'b1;
         mux_address_bus_out <= 8'h00;
         din_out             <= 1'b0;
         t_load              <= 1'b0;
         t_val               <= 8'h00;
         ras_load            <= 1'b0;
         ref_done            <= 1'b0;
      end
      else
      begin
         t_load       <= 1'b0;
         ras_load     <= 1'b0;
         ref_done     <= 1'b0;
         rd_valid_out <= 1'b0;
         case (state)
            S_PWR:
            begin
               if (long_cnt < PWRUP_CYC)
                  long_cnt <= long_cnt + 32'h1;
               else
               begin
                  init_cnt <= INIT_CNT;
                  long_cnt <= 32'h0;
                  state    <= S_IDLE;
               end
            end
            S_IDLE:
            begin
               long_cnt <= (long_cnt < IDLE_CYC) ? long_cnt + 32'h1 : long_cnt;
               if (long_cnt >= IDLE_CYC && !ext_active_out)
               begin
                  init_done_out <= 1'b0;
                  init_cnt      <= INIT_CNT;
                  long_cnt      <= 32'h0;
               end
               else if (ext_refresh_in != ext_want && burst_cnt == 9'h000)
               begin
                  ext_want  <= ext_refresh_in;
                  burst_cnt <= ROWS_ALL;
               end
               else if (init_cnt != ROWS_LAST || burst_cnt != 9'h000 || ref_req)
               begin
                  is_ref              <= 1'b1;
                  mux_address_bus_out <= ref_row;
                  state               <= S_REF;
               end
               else if (burst_cnt == 9'h000 && ext_want != ext_active_out)
                  ext_active_out <= ext_want;
               else if (req_valid_in && req_ready_out)
               begin
                  op                  <= req_op_in;
                  mux_address_bus_out <= req_addr_in[15:8];
                  col                 <= req_addr_in[7:0];
                  wbit                <= req_wdata_in;
                  is_ref              <= 1'b0;
                  state               <= S_REF;
               end
            end
            S_REF:
            begin
               // address set up one cycle, then row strobe falls
               ras_n_out <= 1'b0;
               ras_load  <= 1'b1;
               long_cnt  <= 32'h0;
               t_load    <= 1'b1;
               t_val     <= is_ref ? T_RAS : T_RCD;
               state     <= is_ref ? S_RHOLD : S_ROW;
            end
            S_ROW:
            begin
               if (t_done)
               begin
                  // row hold covered by delay; column now driven
                  mux_address_bus_out <= col;
                  din_out             <= wbit;
                  we_n_out            <= (op == `LPD_OP_WRITE) ? 1'b0 : 1'b1;
                  state               <= S_COL;
               end
            end
            S_COL:
            begin
               cas_n_out <= 1'b0;
               t_load    <= 1'b1;
               t_val     <= (op == `LPD_OP_WRITE) ? T_CW : T_ACC;
               state     <= (op == `LPD_OP_WRITE) ? S_CHOLD : S_SAMP;
            end
            S_SAMP:
            begin
               if (t_done)
               begin
                  // wait starts a cycle after the fall; margin covers both sync flops
                  rd_data_out  <= dout_s2;
                  rd_valid_out <= 1'b1;
                  if (op == `LPD_OP_RMW)
                  begin
                     din_out  <= wbit;
                     we_n_out <= 1'b0;
                     t_load   <= 1'b1;
                     t_val    <= T_WP;
                     state    <= S_WLATE;
                  end
                  else
                     state <= S_CHOLD;
               end
            end
            S_WLATE:
            begin
               // column strobe already low past rmw minimum
               if (t_done)
                  state <= S_CHOLD;
            end
            S_CHOLD:
            begin
               // column address held well past hold-from-row
               if (ras_done)
               begin
                  cas_n_out <= 1'b1;
                  ras_n_out <= 1'b1;
                  we_n_out  <= 1'b1;
                  t_load    <= 1'b1;
                  t_val     <= T_RP;
                  state     <= S_PRE;
               end
            end
            S_RHOLD:
            begin
               if (ras_done)
               begin
                  ras_n_out <= 1'b1;
                  t_load    <= 1'b1;
                  t_val     <= T_RP;
                  ref_done  <= 1'b1;
                  if (burst_cnt != 9'h000)
                     burst_cnt <= burst_cnt - 9'h001;
                  if (init_cnt != ROWS_LAST)
                     init_cnt <= init_cnt - 4'h1;
                  state <= S_PRE;
               end
            end
            S_PRE:
            begin
               // rp exceeds cp, so one wait covers both
               if (t_done)
               begin
                  if (init_cnt == ROWS_LAST)
                     init_done_out <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule // lpd_ctrl
`default_nettype wire

// ==== lpd_ctrl_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpd_ctrl_sva #(
   parameter PWRUP_CYC = 10000,
   parameter IDLE_CYC  = 6400000
) (
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   input wire logic        req_valid_in,
   input wire logic [1:0]  req_op_in,
   input wire logic [15:0] req_addr_in,
   input wire logic        req_wdata_in,
   input wire logic        ext_refresh_in,
   input wire logic        req_ready_out,
   input wire logic        rd_valid_out,
   input wire logic        rd_data_out,
   input wire logic        init_done_out,
   input wire logic        ext_active_out,
   input wire logic        ras_n_out,
   input wire logic        cas_n_out,
   input wire logic        we_n_out,
   input wire logic [7:0]  mux_address_bus_out,
   input wire logic        din_out,
   input wire logic        dout_in
);
   logic [31:0] cyc;
   logic [3:0]  falls;
   logic [7:0]  ras_cnt;
   logic [7:0]  cas_cnt;
   logic        we_q;
   logic        rmw;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // ==========================================================
   // helper counters: strobe low widths, cycles since reset
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         cyc     <= 32'h0;
         falls   <= 4'h0;
         ras_cnt <= 8'h0;
         cas_cnt <= 8'h0;
         we_q    <= 1'b1;
         rmw     <= 1'b0;
      end
      else
      begin
         if (cyc != 32'hFFFFFFFF) cyc <= cyc + 32'h1;
         // init pulses are counted afresh after every loss of init
         if (init_done_out) falls <= 4'h0;
         else if (!ras_n_out && ras_cnt == 8'h0 && falls != 4'hF) falls <= falls + 4'h1;
         ras_cnt <= ras_n_out ? 8'h0 : ((ras_cnt == 8'hFF) ? ras_cnt : ras_cnt + 8'h1);
         cas_cnt <= cas_n_out ? 8'h0 : ((cas_cnt == 8'hFF) ? cas_cnt : cas_cnt + 8'h1);
         we_q    <= we_n_out;
         rmw     <= !cas_n_out && (rmw || (we_q && !we_n_out));
      end
   end
   sequence s_write_strobe;
      $fell(cas_n_out) && !we_n_out;
   endsequence
   sequence s_rmw_strobe;
      $fell(we_n_out) && !cas_n_out;
   endsequence
   // ==========================================================
   // strobe timing
   AST_RAS_ACTIVE_MIN: assert property ($rose(ras_n_out) |-> ras_cnt >= 8'd10)
      else $error("row strobe low too short");
   AST_RAS_PRECHARGE: assert property ($rose(ras_n_out) |-> ras_n_out[*5])
      else $error("row precharge too short");
   AST_IDLE_STROBES: assert property (ras_n_out |-> we_n_out && cas_n_out)
      else $error("strobe low outside row cycle");
   AST_ROW_HOLD: assert property ($fell(ras_n_out) |-> $stable(mux_address_bus_out)[*2])
      else $error("row address not held");
   AST_COL_LATCH: assert property ($fell(cas_n_out) |->
      ras_cnt >= 8'd3 ##0 $stable(mux_address_bus_out)[*2])
      else $error("column address timing");
   AST_WRITE_DATA: assert property (s_write_strobe |-> $stable(din_out)[*3])
      else $error("write data not held");
   AST_RMW_WE_DELAY: assert property (s_rmw_strobe |-> ras_cnt >= 8'd10 && cas_cnt >= 8'd2)
      else $error("write strobe too early in rmw");
   AST_RMW_CAS_WIDTH: assert property ($rose(cas_n_out) && rmw |-> cas_cnt >= 8'd6)
      else $error("rmw column strobe too short");
   // two cycles of slack for the registered strobe launch
   AST_NO_RAS_IN_PAUSE: assert property ($fell(ras_n_out) |-> cyc >= PWRUP_CYC - 2)
      else $error("row strobe during power-up pause");
   AST_INIT_PULSES: assert property ($rose(init_done_out) |-> falls >= 4'd8)
      else $error("too few init cycles");
   AST_READY_NEEDS_INIT: assert property (req_ready_out |-> init_done_out && ras_n_out)
      else $error("ready before init or in cycle");
endmodule // lpd_ctrl_sva
`default_nettype wire

// ==== lpd_dram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpd_dram_model (
   input  wire logic       ras_n_in,
   input  wire logic       cas_n_in,
   input  wire logic       we_n_in,
   input  wire logic [7:0] mux_address_bus_in,
   input  wire logic       din_in,
   output var  logic       dout_out
);
   logic       cells [0:65535];
   logic [7:0] row;
   logic [7:0] col;
   logic       driving = 1'b0;
   realtime    t_ras;
   realtime    t_cas;
   realtime    acc;
   realtime    t_addr;
   initial dout_out = 1'b0;
   // ==========================================================
   // strobe-edge behaviour
   always @(mux_address_bus_in) t_addr = $realtime;
   always @(negedge ras_n_in)
   begin
      row = mux_address_bus_in;
      t_ras = $realtime;
   end
   always @(negedge cas_n_in)
   begin
      if (!ras_n_in)
      begin
         col = mux_address_bus_in;
         t_cas = $realtime;
         if (!we_n_in) cells[{row, col}] = din_in;
         else
         begin
            // data valid only once all three access limits have run out
            acc = 100.0 - (t_cas - t_ras);
            if (acc < 55.0 - (t_cas - t_addr)) acc = 55.0 - (t_cas - t_addr);
            if (acc < 20.0) acc = 20.0;
            driving = 1'b1;
            dout_out <= #(acc) cells[{row, col}];
         end
      end
   end
   always @(negedge we_n_in)
   begin
      if (!cas_n_in && !ras_n_in)
      begin
         if ($realtime - t_ras < 100.0 || $realtime - t_cas < 20.0
             || $realtime - t_addr < 55.0) dout_out = 1'bx;
         cells[{row, col}] = din_in;
      end
   end
   // released output shows the inverse, never a stale valid bit
   always @(posedge cas_n_in)
   begin
      if (driving) dout_out = ~dout_out;
      driving = 1'b0;
   end
endmodule // lpd_dram_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        valid = 1'b0;
   logic [1:0]  op = 2'h0;
   logic [15:0] addr = 16'h0000;
   logic        wdata = 1'b0;
   logic        ext = 1'b0;
   wire         ready, rd_valid, rd_data, init_done, ext_active;
   wire         ras_n, cas_n, we_n, din, dout;
   wire  [7:0]  bus;
   logic [7:0]  row_seen, col_seen, row_at_cas;
   int          mismatches = 0;
   int          compares = 0;
   int          ras_falls = 0;
   logic [15:0] at [4] = '{16'h0000, 16'hFFFF, 16'hA55A, 16'h5AA5};
   logic        dt [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   always #5 clk = ~clk;
   always @(negedge ras_n)
   begin
      row_seen = bus;
      ras_falls++;
   end
   always @(negedge cas_n)
   begin
      col_seen = bus;
      row_at_cas = row_seen;
   end
   lpd_ctrl #(.PWRUP_CYC(20), .IDLE_CYC(200)) lpd_ctrl_i (
      .ref_clk_in(clk), .rst_in(rst), .req_valid_in(valid), .req_op_in(op),
      .req_addr_in(addr), .req_wdata_in(wdata), .ext_refresh_in(ext),
      .req_ready_out(ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
      .init_done_out(init_done), .ext_active_out(ext_active), .ras_n_out(ras_n),
      .cas_n_out(cas_n), .we_n_out(we_n), .mux_address_bus_out(bus),
      .din_out(din), .dout_in(dout));
   lpd_dram_model lpd_dram_model_i (
      .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
      .mux_address_bus_in(bus), .din_in(din), .dout_out(dout));
   // ==========================================================
   // compare and bus tasks
   task automatic check1(input string what, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim);
      int k;
      k = 0;
      do begin @(posedge clk); k++; end while (s !== v && k < lim);
   endtask
   task automatic do_req(input logic [1:0] o, input logic [15:0] a, input logic d,
                         input logic e);
      logic r;
      valid <= 1'b1;
      op    <= o;
      addr  <= a;
      wdata <= d;
      do begin @(posedge clk); r = ready; end while (r !== 1'b1 && $time < 390000);
      valid <= 1'b0;
      if (o != 2'h1)
      begin
         do @(posedge clk); while (rd_valid !== 1'b1 && $time < 390000);
         check1("read data", e, rd_data);
      end
      do @(posedge clk); while (ready !== 1'b1 && $time < 390000);
      check8("row half", a[15:8], row_at_cas);
      check8("column half", a[7:0], col_seen);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_init;
      do @(posedge clk); while (init_done !== 1'b1 && $time < 20000);
      check1("init done", 1'b1, init_done);
      check1("init pulses", 1'b1, ras_falls >= 8);
      $display("t_init done");
   endtask
   task automatic t_write_read;
      for (int i = 0; i < 4; i++) do_req(2'h1, at[i], dt[i], 1'b0);
      for (int i = 0; i < 4; i++) do_req(2'h0, at[i], 1'b0, dt[i]);
      $display("t_write_read done");
   endtask
   task automatic t_rmw;
      do_req(2'h2, at[2], 1'b0, 1'b1);
      do_req(2'h2, at[1], 1'b1, 1'b0);
      do_req(2'h0, at[2], 1'b0, 1'b0);
      do_req(2'h0, at[1], 1'b0, 1'b1);
      $display("t_rmw done");
   endtask
   task automatic t_idle;
      int f0;
      f0 = ras_falls;
      // long enough that one periodic refresh cannot hide the idle span
      repeat (450) @(posedge clk);
      do_req(2'h0, at[3], 1'b0, 1'b1);
      check1("idle reinit", 1'b1, ras_falls - f0 >= 8);
      $display("t_idle done");
   endtask
   task automatic t_ext;
      int f0;
      f0 = ras_falls;
      ext <= 1'b1;
      do @(posedge clk); while (ext_active !== 1'b1 && $time < 390000);
      check1("extended mode", 1'b1, ext_active);
      check1("ready in extended mode", 1'b0, ready);
      check1("entry burst", 1'b1, ras_falls - f0 >= 256);
      f0 = ras_falls;
      ext <= 1'b0;
      do @(posedge clk); while (ready !== 1'b1 && $time < 390000);
      check1("extended mode off", 1'b0, ext_active);
      check1("exit burst", 1'b1, ras_falls - f0 >= 256);
      do_req(2'h0, at[0], 1'b0, 1'b1);
      $display("t_ext done");
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_init;
      t_write_read;
      t_rmw;
      t_idle;
      t_ext;
      summarize;
   end
   initial
   begin
      #400000;
      mismatches++;
      $display("watchdog expired");
      summarize;
   end
endmodule // testbench
bind lpd_ctrl lpd_ctrl_sva #(.PWRUP_CYC(PWRUP_CYC), .IDLE_CYC(IDLE_CYC)) lpd_ctrl_sva_i (
   .ref_clk_in, .rst_in, .req_valid_in, .req_op_in, .req_addr_in, .req_wdata_in,
   .ext_refresh_in, .req_ready_out, .rd_valid_out, .rd_data_out, .init_done_out,
   .ext_active_out, .ras_n_out, .cas_n_out, .we_n_out, .mux_address_bus_out,
   .din_out, .dout_in);
`default_nettype wire
